/* rtl/adc_ctrl_pkg.sv */
// constants and carriers of the converter mode and result control
// assumes one 10 MHz clock and a word-indexed Avalon-MM slave
package adc_ctrl_pkg;
	localparam int CLK_PERIOD_NS = 100;
	// word index on ADDRESS[3:2]
	localparam logic [1:0] OFS_CTRL = 2'h0;
	localparam logic [1:0] OFS_STATUS = 2'h1;
	localparam logic [1:0] OFS_RESULT = 2'h2;
	// resolution codes in mode bits 1:0
	localparam logic [1:0] RES_10 = 2'h0;
	localparam logic [1:0] RES_12 = 2'h1;
	localparam logic [1:0] RES_8 = 2'h2;
	localparam logic [1:0] RES_NONE = 2'h3;
	localparam int MODE_STAY_ON_BIT = 2;
	localparam int MODE_CAL_SKIP_BIT = 3;
	// control word fields
	localparam int CTRL_START_BIT = 4;
	localparam int CTRL_TEMP_BIT = 5;
	localparam int CTRL_PDN_BIT = 6;
	localparam int CTRL_DRIVE_BIT = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// status word fields
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_CAL_BIT = 1;
	localparam int ST_DONE_BIT = 2;
	localparam int ST_SAT_BIT = 3;
	localparam int ST_PWR_BIT = 4;
	localparam int ST_CMP_BIT = 5;
	// conversion timing
	localparam logic [3:0] CAL_CYCLES = 4'h2;
	localparam int SAMPLE_TIME_NS = 200;
	localparam int SAMPLE_CYC = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SAMPLE_CYCLES = 4'(SAMPLE_CYC < 1 ? 1 : SAMPLE_CYC);
	localparam logic [3:0] BITS_8 = 4'h8;
	localparam logic [3:0] BITS_10 = 4'hA;
	localparam logic [3:0] BITS_12 = 4'hC;
	localparam logic [11:0] FULL_SCALE = 12'hFFF;

	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_CALIB} conv_state_e;

	typedef struct packed {
		logic drive;
		logic pdn;
		logic temp;
		logic [3:0] mode;
	} ctrl_s;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [1:0] word;
		logic [31:0] wdata;
	} bus_req_s;
endpackage

/* rtl/adc_mode_result_control.sv */
// converter mode, sequencing and result control behind an Avalon-MM slave
// assumes analog-side inputs are asynchronous and a master that holds
// each request until it sees WAITREQUEST low
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module adc_mode_result_control
	import adc_ctrl_pkg::*;
(
	input wire logic MCLK,
	input wire logic NRST,
	input wire logic [3:0] ADDRESS,
	input wire logic READ,
	input wire logic WRITE,
	input wire logic [31:0] WRITEDATA,
	output logic [31:0] READDATA,
	output logic WAITREQUEST,
	input wire logic [11:0] RAW_CODE,
	input wire logic OVER_RANGE,
	input wire logic EXTEST,
	output logic BUSY,
	output logic CALIBRATING,
	output logic DATA_VALID,
	output logic [11:0] RESULT,
	output logic CONVERTER_POWER,
	output logic COMPARATOR_ENABLE,
	output logic SAMPLE_HOLD,
	output logic TEMP_CURRENT_SEL,
	output logic GATE_DRIVE_OUT,
	output logic GATE_DRIVE_OE,
	output logic GATE_SINK_EN
);

	// place a conversion code on the result bus by resolution
	function automatic logic [11:0] place_code(input logic [11:0] c, input logic [1:0] r);
		case (r)
			RES_8: place_code = {c[11:4], 4'h0};
			RES_10: place_code = {c[11:2], 2'h0};
			default: place_code = c;
		endcase
	endfunction

	function automatic logic [3:0] conv_bits(input logic [1:0] r);
		case (r)
			RES_8: conv_bits = BITS_8;
			RES_12: conv_bits = BITS_12;
			default: conv_bits = BITS_10;
		endcase
	endfunction

	// two-flop synchronisers for analog-side inputs
	logic [13:0] meta_q;
	logic [13:0] sync_q;
	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			meta_q <= 14'h0000;
			sync_q <= 14'h0000;
		end else begin
			meta_q <= {EXTEST, OVER_RANGE, RAW_CODE};
			sync_q <= meta_q;
		end
	end
	logic [11:0] code_s;
	logic over_s;
	logic ext_s;
	assign code_s = sync_q[11:0];
	assign over_s = sync_q[12];
	assign ext_s = sync_q[13];

	bus_req_s req;
	assign req = '{rd: READ, wr: WRITE, word: ADDRESS[3:2], wdata: WRITEDATA};

	conv_state_e state_q, state_d;
	ctrl_s ctrl_q, ctrl_d;
	logic [3:0] mode_q, mode_d;
	logic [3:0] cnt_q, cnt_d;
	logic temp_run_q, temp_run_d;
	logic done_q, done_d;
	logic sat_q, sat_d;
	logic [31:0] rdata_q, rdata_d;
	logic wait_q, wait_d;
	logic busy_q, busy_d;
	logic cal_q, cal_d;
	logic valid_q, valid_d;
	logic [11:0] result_q, result_d;
	logic pwr_q, pwr_d;
	logic cmp_q, cmp_d;
	logic hold_q, hold_d;
	logic tsel_q, tsel_d;
	logic gout_q, gout_d;
	logic goe_q, goe_d;
	logic gsink_q, gsink_d;

	logic acc;
	logic start_req;
	logic temp_rise;
	logic [11:0] conv_val;

	always_comb begin
		acc = (req.rd || req.wr) && !wait_q;
		ctrl_d = ctrl_q;
		done_d = done_q;
		wait_d = !((req.rd || req.wr) && wait_q);
		rdata_d = rdata_q;
		start_req = 1'b0;
		if (acc && req.wr && req.word == OFS_CTRL) begin
			// start is a strobe and is not kept in the control word
			ctrl_d.mode = req.wdata[3:0];
			ctrl_d.temp = req.wdata[CTRL_TEMP_BIT];
			ctrl_d.pdn = req.wdata[CTRL_PDN_BIT];
			ctrl_d.drive = req.wdata[CTRL_DRIVE_BIT];
			start_req = req.wdata[CTRL_START_BIT];
		end
		if (acc && req.wr && req.word == OFS_STATUS && req.wdata[ST_DONE_BIT]) begin
			done_d = 1'b0;
		end
		if ((req.rd || req.wr) && wait_q) begin
			case (req.word)
				OFS_CTRL: rdata_d = {24'h000000, ctrl_q.drive, ctrl_q.pdn, ctrl_q.temp, 1'b0,
					ctrl_q.mode};
				OFS_STATUS: rdata_d = {26'h0000000, cmp_q, pwr_q, sat_q, done_q, cal_q, busy_q};
				OFS_RESULT: rdata_d = {20'h00000, result_q};
				default: rdata_d = 32'h00000000;
			endcase
		end
		temp_rise = ctrl_d.temp && !ctrl_q.temp;
		state_d = state_q;
		mode_d = mode_q;
		cnt_d = cnt_q;
		temp_run_d = temp_run_q;
		sat_d = sat_q;
		result_d = result_q;
		valid_d = 1'b0;
		pwr_d = pwr_q;
		conv_val = over_s ? FULL_SCALE : code_s;
		case (state_q)
			ST_IDLE: begin
				if ((start_req || temp_rise) && ctrl_d.mode[1:0] != RES_NONE) begin
					state_d = ST_SAMPLE;
					mode_d = ctrl_d.mode;
					cnt_d = SAMPLE_CYCLES - 4'h1;
					temp_run_d = temp_rise;
					pwr_d = 1'b1;
				end
			end
			ST_SAMPLE: begin
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h0) begin
					state_d = ST_CONVERT;
					cnt_d = conv_bits(mode_q[1:0]) - 4'h1;
				end
			end
			ST_CONVERT: begin
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h0) begin
					result_d = place_code(conv_val, mode_q[1:0]);
					sat_d = over_s;
					if (!mode_q[MODE_CAL_SKIP_BIT]) begin
						state_d = ST_CALIB;
						cnt_d = CAL_CYCLES - 4'h1;
					end else begin
						state_d = ST_IDLE;
					end
				end
			end
			ST_CALIB: begin
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h0) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		if (state_q != ST_IDLE && state_d == ST_IDLE) begin
			valid_d = 1'b1;
			done_d = 1'b1;
			temp_run_d = 1'b0;
			pwr_d = mode_q[MODE_STAY_ON_BIT];
		end
		busy_d = state_d != ST_IDLE;
		cal_d = state_d == ST_CALIB;
		hold_d = state_d == ST_SAMPLE;
		tsel_d = temp_run_d && state_d != ST_IDLE;
		cmp_d = pwr_d && !ctrl_d.pdn;
		gout_d = ctrl_d.drive;
		goe_d = !ext_s;
		gsink_d = ext_s;
	end

	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			state_q <= ST_IDLE;
			ctrl_q.mode <= CTRL_RESET[3:0];
			ctrl_q.temp <= CTRL_RESET[CTRL_TEMP_BIT];
			ctrl_q.pdn <= CTRL_RESET[CTRL_PDN_BIT];
			ctrl_q.drive <= CTRL_RESET[CTRL_DRIVE_BIT];
			mode_q <= 4'h0;
			cnt_q <= 4'h0;
			temp_run_q <= 1'b0;
			done_q <= 1'b0;
			sat_q <= 1'b0;
			rdata_q <= 32'h00000000;
			wait_q <= 1'b1;
			busy_q <= 1'b0;
			cal_q <= 1'b0;
			valid_q <= 1'b0;
			result_q <= 12'h000;
			pwr_q <= 1'b0;
			cmp_q <= 1'b0;
			hold_q <= 1'b0;
			tsel_q <= 1'b0;
			gout_q <= 1'b0;
			goe_q <= 1'b1;
			gsink_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
			mode_q <= mode_d;
			cnt_q <= cnt_d;
			temp_run_q <= temp_run_d;
			done_q <= done_d;
			sat_q <= sat_d;
			rdata_q <= rdata_d;
			wait_q <= wait_d;
			busy_q <= busy_d;
			cal_q <= cal_d;
			valid_q <= valid_d;
			result_q <= result_d;
			pwr_q <= pwr_d;
			cmp_q <= cmp_d;
			hold_q <= hold_d;
			tsel_q <= tsel_d;
			gout_q <= gout_d;
			goe_q <= goe_d;
			gsink_q <= gsink_d;
		end
	end

	assign READDATA = rdata_q;
	assign WAITREQUEST = wait_q;
	assign BUSY = busy_q;
	assign CALIBRATING = cal_q;
	assign DATA_VALID = valid_q;
	assign RESULT = result_q;
	assign CONVERTER_POWER = pwr_q;
	assign COMPARATOR_ENABLE = cmp_q;
	assign SAMPLE_HOLD = hold_q;
	assign TEMP_CURRENT_SEL = tsel_q;
	assign GATE_DRIVE_OUT = gout_q;
	assign GATE_DRIVE_OE = goe_q;
	assign GATE_SINK_EN = gsink_q;

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!NRST);

	a_temp_start: assert property (state_q == ST_IDLE && temp_rise && ctrl_d.mode[1:0] != RES_NONE
		|=> SAMPLE_HOLD && TEMP_CURRENT_SEL) else $error("temp strobe did not start");
	a_comp_off: assert property (ctrl_q.pdn |-> !COMPARATOR_ENABLE)
		else $error("comparators on while powered down");
	a_res_unused: assert property (state_q == ST_IDLE && start_req && ctrl_d.mode[1:0] == RES_NONE
		|=> !BUSY) else $error("unused resolution started");
	a_conv_len8: assert property ($rose(state_q == ST_CONVERT) && mode_q[1:0] == RES_8
		|-> (state_q == ST_CONVERT)[*8] ##1 state_q != ST_CONVERT)
		else $error("8-bit conversion length wrong");
	a_power_after: assert property ($fell(BUSY) && !mode_q[MODE_STAY_ON_BIT] |-> !CONVERTER_POWER)
		else $error("converter not powered down");
	a_cal_two: assert property ($rose(CALIBRATING) |-> CALIBRATING[*2] ##1 !CALIBRATING)
		else $error("calibration not two cycles");
	a_cal_skip: assert property (state_q == ST_CONVERT && cnt_q == 4'h0 && mode_q[MODE_CAL_SKIP_BIT]
		|=> !CALIBRATING && !BUSY) else $error("calibration not skipped");
	a_result_read: assert property (req.rd && wait_q && req.word == OFS_RESULT
		|=> READDATA == {20'h00000, $past(RESULT)}) else $error("result read mismatch");
	a_res8_low: assert property (DATA_VALID && mode_q[1:0] == RES_8 |-> RESULT[3:0] == 4'h0)
		else $error("8-bit low bits not zero");
	a_res10_low: assert property (DATA_VALID && mode_q[1:0] == RES_10 |-> RESULT[1:0] == 2'h0)
		else $error("10-bit low bits not zero");
	a_saturate: assert property (state_q == ST_CONVERT && cnt_q == 4'h0 && over_s
		|=> RESULT == place_code(FULL_SCALE, mode_q[1:0]))
		else $error("no saturation at full scale");
	a_extest_sink: assert property (ext_s |=> GATE_SINK_EN && !GATE_DRIVE_OE)
		else $error("gate pad still driving");

	c_conv_cal: cover property ($rose(CALIBRATING) ##2 DATA_VALID);
	c_temp_conv: cover property (TEMP_CURRENT_SEL ##[1:40] DATA_VALID);
	c_saturated: cover property (DATA_VALID && sat_q);
	c_stay_on: cover property ($fell(BUSY) && CONVERTER_POWER);

endmodule // adc_mode_result_control

`default_nettype wire

/* tb/adc_mode_result_control_tb.sv */
// self-checking bench of the converter mode and result control
// assumes the analog front model and a 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module adc_mode_result_control_tb;
	import adc_ctrl_pkg::*;
	logic MCLK = 1'b0;
	logic NRST = 1'b0;
	logic [3:0] ADDRESS = 4'h0;
	logic READ = 1'b0;
	logic WRITE = 1'b0;
	logic [31:0] WRITEDATA = 32'h0;
	logic EXTEST = 1'b0;
	logic [11:0] next_code = 12'h000;
	logic next_ovr = 1'b0;
	logic [31:0] READDATA;
	logic [11:0] RAW_CODE, RESULT;
	logic WAITREQUEST, OVER_RANGE, BUSY, CALIBRATING, DATA_VALID, CONVERTER_POWER;
	logic COMPARATOR_ENABLE, SAMPLE_HOLD, TEMP_CURRENT_SEL, GATE_DRIVE_OUT;
	logic GATE_DRIVE_OE, GATE_SINK_EN;
	logic [15:0] lfsr_q = 16'hBA9B;
	logic [31:0] rd;
	int bad_count = 0;
	int n_compared = 0;
	int n;
	int nc;
	int e;
	logic [1:0] res_tab [3] = '{RES_8, RES_10, RES_12};

	adc_mode_result_control i_adc_mode_result_control (.MCLK, .NRST, .ADDRESS, .READ, .WRITE,
		.WRITEDATA, .READDATA, .WAITREQUEST, .RAW_CODE, .OVER_RANGE, .EXTEST, .BUSY,
		.CALIBRATING, .DATA_VALID, .RESULT, .CONVERTER_POWER, .COMPARATOR_ENABLE,
		.SAMPLE_HOLD, .TEMP_CURRENT_SEL, .GATE_DRIVE_OUT, .GATE_DRIVE_OE, .GATE_SINK_EN);
	analog_front_model i_analog_front_model (.clk(MCLK), .busy(BUSY), .sample_hold(SAMPLE_HOLD),
		.next_code(next_code), .next_ovr(next_ovr), .raw_code(RAW_CODE), .over_range(OVER_RANGE));

	always #50 MCLK = ~MCLK;

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// reference model of the result bus
	function automatic int exp_res(input int res, input int raw, input bit ovr);
		int v;
		v = ovr ? 'hFFF : raw;
		if (res == RES_8) return v & 'hFF0;
		if (res == RES_10) return v & 'hFFC;
		return v;
	endfunction

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [1:0] word, input logic [31:0] wd);
		int i;
		@(posedge MCLK);
		ADDRESS <= {word, 2'b00};
		READ <= !wr;
		WRITE <= wr;
		WRITEDATA <= wd;
		for (i = 0; i < 20; i++) begin
			@(posedge MCLK);
			if (WAITREQUEST === 1'b0) break;
		end
		if (i == 20) begin
			bad_count++;
			end_of_test();
		end
		rd = READDATA;
		READ <= 1'b0;
		WRITE <= 1'b0;
	endtask

	// counts busy cycles up to the data-valid edge
	task automatic wait_done;
		int i;
		n = 0;
		nc = 0;
		for (i = 0; i < 60; i++) begin
			@(posedge MCLK);
			if (DATA_VALID === 1'b1) break;
			if (BUSY === 1'b1) n++;
			if (CALIBRATING === 1'b1) nc++;
		end
		if (i == 60) begin
			bad_count++;
			end_of_test();
		end
	endtask

	task automatic conv(input logic [3:0] mode, input bit ovr);
		int bits;
		lfsr_q = lfsr_next(lfsr_q);
		next_code <= lfsr_q[11:0];
		next_ovr <= ovr;
		bus(1'b1, OFS_CTRL, 32'(mode) | (32'h1 << CTRL_START_BIT));
		wait_done();
		bits = mode[1:0] == RES_8 ? 8 : (mode[1:0] == RES_10 ? 10 : 12);
		e = exp_res(mode[1:0], lfsr_q[11:0], ovr);
		chk(n, SAMPLE_CYCLES + bits + (mode[3] ? 0 : 2));
		chk(nc, mode[3] ? 0 : 2);
		chk(RESULT, e);
		chk(CONVERTER_POWER, mode[2]);
		bus(1'b0, OFS_RESULT, 32'h0);
		chk(rd, e);
		$display("conversion mode %h done", mode);
	endtask

	initial begin
		repeat (5) @(posedge MCLK);
		NRST <= 1'b1;
		chk(WAITREQUEST, 1'b1);
		chk(GATE_DRIVE_OE, 1'b1);
		bus(1'b1, 2'h3, 32'hFFFF_FFFF);
		bus(1'b0, 2'h3, 32'h0);
		chk(rd, 32'h0);
		$display("unmapped word done");
		for (int k = 0; k < 12; k++)
			conv({k >= 6, (k / 3) % 2 == 1, res_tab[k % 3]}, k == 4 || k == 9);
		bus(1'b1, OFS_CTRL, 32'h13);
		repeat (3) @(posedge MCLK);
		chk(BUSY, 1'b0);
		$display("unused resolution done");
		bus(1'b1, OFS_CTRL, (32'h1 << CTRL_TEMP_BIT) | 32'h5);
		@(posedge MCLK);
		chk(TEMP_CURRENT_SEL, 1'b1);
		chk(SAMPLE_HOLD, 1'b1);
		chk(BUSY, 1'b1);
		wait_done();
		bus(1'b1, OFS_CTRL, 32'h0);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rd, (32'h1 << ST_DONE_BIT) | (32'h1 << ST_PWR_BIT) | (32'h1 << ST_CMP_BIT));
		bus(1'b1, OFS_STATUS, 32'h1 << ST_DONE_BIT);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rd, (32'h1 << ST_PWR_BIT) | (32'h1 << ST_CMP_BIT));
		$display("temperature strobe done");
		bus(1'b1, OFS_CTRL, (32'h1 << CTRL_PDN_BIT) | (32'h1 << CTRL_START_BIT) | 32'h6);
		@(posedge MCLK);
		chk(COMPARATOR_ENABLE, 1'b0);
		chk(BUSY, 1'b1);
		chk(CONVERTER_POWER, 1'b1);
		wait_done();
		$display("comparator power-down done");
		bus(1'b1, OFS_CTRL, 32'h1 << CTRL_DRIVE_BIT);
		@(posedge MCLK);
		chk(GATE_DRIVE_OUT, 1'b1);
		chk(GATE_DRIVE_OE, 1'b1);
		EXTEST <= 1'b1;
		for (int i = 0; i < 10 && GATE_SINK_EN !== 1'b1; i++)
			@(posedge MCLK);
		chk(GATE_SINK_EN, 1'b1);
		chk(GATE_DRIVE_OE, 1'b0);
		$display("boundary scan sink done");
		end_of_test();
	end
endmodule // adc_mode_result_control_tb
`default_nettype wire

/* tb/analog_front_model.sv */
// analog front end: comparator code and over-range level
// assumes the code is latched while the sample phase runs
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
	input wire logic clk,
	input wire logic busy,
	input wire logic sample_hold,
	input wire logic [11:0] next_code,
	input wire logic next_ovr,
	output logic [11:0] raw_code = 12'h5A5,
	output logic over_range = 1'b0
);
	always @(posedge clk) begin
		if (sample_hold) begin
			raw_code <= next_code;
			over_range <= next_ovr;
		end else if (!busy) begin
			// idle code churns so a stale sample cannot pass
			raw_code <= ~raw_code;
			over_range <= 1'b0;
		end
	end
endmodule // analog_front_model
`default_nettype wire
